/* File: common/fdcst_pkg.sv */
// Purpose: Shared constants for the floppy controller status block
// Assumes: Host register select codes and status bit layout as wired on the chip
// Notes:   Command types decide which meaning status bits 6 to 1 carry
package fdcst_pkg;

    typedef enum logic [2:0] {
        CMD_POSITION  = 3'b000,
        CMD_RD_SECTOR = 3'b001,
        CMD_RD_ADDR   = 3'b010,
        CMD_RD_TRACK  = 3'b011,
        CMD_WR_SECTOR = 3'b100,
        CMD_WR_TRACK  = 3'b101
    } fdcst_cmd_t;

    localparam logic [1:0] REG_STATUS = 2'h0;
    localparam logic [1:0] REG_DATA   = 2'h3;

    localparam int STATUS_W      = 8;
    localparam int BIT_NOT_READY = 7;
    localparam int BIT_S6        = 6;
    localparam int BIT_S5        = 5;
    localparam int BIT_S4        = 4;
    localparam int BIT_S3        = 3;
    localparam int BIT_S2        = 2;
    localparam int BIT_S1        = 1;
    localparam int BIT_BUSY      = 0;

    localparam logic [7:0] DAL_RESET = 8'h00;
    localparam logic [1:0] CNT_EMPTY = 2'h0;
    localparam logic [1:0] CNT_ONE   = 2'h1;
    localparam logic [1:0] CNT_FULL  = 2'h2;

endpackage

/* File: dv/fdc_status_and_format_rules_bench.sv */
// Purpose: Self-checking bench for the floppy controller status block
// Assumes: Host strobes driven 1 ns after the rising clock edge
// Notes:   Drive model feeds read bytes and drains write bytes slowly
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, a, b); end end
module fdc_status_and_format_rules_bench;
    import fdcst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, master_reset_input_n_i = 1'b1;
    logic chip_select_n_i = 1'b1, read_enable_n_i = 1'b1, write_enable_n_i = 1'b1;
    logic [1:0] reg_sel_i = REG_STATUS;
    logic [7:0] dal_i = 8'h00, dal_o, rd_byte_i, wr_byte_o, s;
    logic ready_i = 1'b1, head_load_output_i = 1'b1, head_load_timing_input_i = 1'b1;
    logic track_zero_input_n_i = 1'b1, index_pulse_input_n_i = 1'b1, write_protect_i = 1'b1;
    logic cmd_load_i = 1'b0, force_int_i = 1'b0, force_imm_i = 1'b0, cmd_done_i = 1'b0;
    logic seek_err_i = 1'b0, record_not_found_i = 1'b0, crc_err_i = 1'b0;
    logic mark_or_fault_i = 1'b0, byte_tick_i = 1'b0;
    logic dal_oe_o, rd_byte_valid_i, rd_byte_ready_o, wr_byte_valid_o, wr_byte_ready_i;
    logic data_request_line_o, interrupt_request_line_o, cmd_refused_o;
    fdcst_cmd_t cmd_type_i = CMD_POSITION;
    int mismatches = 0, n_tests = 0, cycles = 0;
    logic [7:0] bytes [3] = '{8'h5a, 8'ha5, 8'h3c};
    logic [7:0] trk [$];
    // {reset_n, ready, head load, load timing, track zero_n, index_n}, then status, bit 6 masked
    logic [13:0] rows [5] = '{{6'b111111, 8'h20}, {6'b101011, 8'h80}, {6'b111000, 8'h06},
                              {6'b011111, 8'ha0}, {6'b110101, 8'h04}};

    fdcst_status dut (
        .clk_sys_i, .reset_i, .master_reset_input_n_i, .chip_select_n_i, .read_enable_n_i,
        .write_enable_n_i, .reg_sel_i, .dal_i, .dal_o, .dal_oe_o, .ready_i,
        .head_load_output_i, .head_load_timing_input_i, .track_zero_input_n_i,
        .index_pulse_input_n_i, .write_protect_i, .cmd_load_i, .cmd_type_i, .force_int_i,
        .force_imm_i, .cmd_done_i, .seek_err_i, .record_not_found_i, .crc_err_i,
        .mark_or_fault_i, .byte_tick_i, .rd_byte_valid_i, .rd_byte_i, .rd_byte_ready_o,
        .wr_byte_valid_o, .wr_byte_o, .wr_byte_ready_i, .data_request_line_o,
        .interrupt_request_line_o, .cmd_refused_o
    );
    fdcst_drive_model drv (
        .clk_sys_i, .rd_byte_valid_o(rd_byte_valid_i), .rd_byte_o(rd_byte_i),
        .rd_byte_ready_i(rd_byte_ready_o), .wr_byte_valid_i(wr_byte_valid_o),
        .wr_byte_i(wr_byte_o), .wr_byte_ready_o(wr_byte_ready_i)
    );

    always #2.5 clk_sys_i = ~clk_sys_i;

    task automatic results();
        $display("%0d comparisons, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Whole run is under six hundred cycles; ceiling leaves wide margin
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            results();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        step(1);
        sig = 1'b0;
    endtask
    task automatic load(input fdcst_cmd_t c);
        cmd_type_i = c;
        pulse(cmd_load_i);
    endtask
    task automatic endt(input string n);
        $display("test %s done", n);
    endtask
    task automatic put(input int n, input logic [7:0] v);
        repeat (n) trk.push_back(v);
    endtask
    // Strobe released one cycle before the next access
    task automatic rd(input logic [1:0] sel, output logic [7:0] v);
        chip_select_n_i = 1'b0;
        read_enable_n_i = 1'b0;
        reg_sel_i       = sel;
        step(1);
        v = dal_o;
        `CHK(dal_oe_o, 1'b1)
        chip_select_n_i = 1'b1;
        read_enable_n_i = 1'b1;
        step(1);
    endtask
    task automatic wr(input logic [7:0] v);
        chip_select_n_i  = 1'b0;
        write_enable_n_i = 1'b0;
        reg_sel_i        = REG_DATA;
        dal_i            = v;
        step(1);
        chip_select_n_i  = 1'b1;
        write_enable_n_i = 1'b1;
        dal_i            = ~v;
        step(1);
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        reset_i = 1'b0;
        `CHK({dal_o, data_request_line_o, interrupt_request_line_o}, 10'h000)
        endt("reset");
        foreach (rows[i])
        begin
            {master_reset_input_n_i, ready_i, head_load_output_i, head_load_timing_input_i,
             track_zero_input_n_i, index_pulse_input_n_i} = rows[i][13:8];
            rd(REG_STATUS, s);
            `CHK(s & 8'hbf, rows[i][7:0])
        end
        endt("positioning rows");
        {master_reset_input_n_i, ready_i} = 2'b10;
        {track_zero_input_n_i, index_pulse_input_n_i} = 2'b11;
        {head_load_output_i, head_load_timing_input_i} = 2'b11;
        load(CMD_RD_SECTOR);
        `CHK({cmd_refused_o, interrupt_request_line_o}, 2'b11)
        rd(REG_STATUS, s);
        `CHK({s[7], s[0], interrupt_request_line_o}, 3'b100)
        endt("refused");
        ready_i = 1'b1;
        load(CMD_RD_SECTOR);
        fork
            begin
                drv.send(bytes[0]);
                drv.send(bytes[1]);
                drv.send(bytes[2]);
            end
        join_none
        for (int k = 0; k < 20 && rd_byte_ready_o; k++)
            step(1);
        `CHK({rd_byte_ready_o, data_request_line_o}, 2'b01)
        rd(REG_STATUS, s);
        `CHK(s[1:0], 2'b11)
        // Host ignores the request for a byte time
        pulse(byte_tick_i);
        pulse(mark_or_fault_i);
        pulse(record_not_found_i);
        pulse(crc_err_i);
        foreach (bytes[i])
        begin
            rd(REG_DATA, s);
            `CHK(s, bytes[i])
        end
        `CHK(data_request_line_o, 1'b0)
        rd(REG_STATUS, s);
        `CHK(s, 8'h3d)
        pulse(cmd_done_i);
        `CHK(interrupt_request_line_o, 1'b1)
        rd(REG_STATUS, s);
        `CHK({s, interrupt_request_line_o}, 9'h078)
        endt("read sector");
        load(CMD_WR_SECTOR);
        `CHK(data_request_line_o, 1'b1)
        foreach (bytes[i])
            wr(bytes[i]);
        for (int k = 0; k < 20 && drv.got.size() < 3; k++)
            step(1);
        `CHK({drv.got[0], drv.got[1], drv.got[2]}, {bytes[0], bytes[1], bytes[2]})
        pulse(mark_or_fault_i);
        rd(REG_STATUS, s);
        `CHK(s, 8'h63)
        pulse(force_int_i);
        rd(REG_STATUS, s);
        `CHK(s, 8'h60)
        pulse(force_int_i);
        rd(REG_STATUS, s);
        `CHK(s & 8'hbf, 8'h20)
        endt("write sector");
        load(CMD_POSITION);
        pulse(seek_err_i);
        pulse(crc_err_i);
        pulse(cmd_done_i);
        rd(REG_STATUS, s);
        `CHK(s & 8'hbf, 8'h38)
        load(CMD_POSITION);
        rd(REG_STATUS, s);
        `CHK(s & 8'hbf, 8'h21)
        force_imm_i = 1'b1;
        pulse(force_int_i);
        force_imm_i = 1'b0;
        rd(REG_STATUS, s);
        `CHK(interrupt_request_line_o, 1'b1)
        pulse(force_int_i);
        rd(REG_STATUS, s);
        `CHK(interrupt_request_line_o, 1'b0)
        endt("positioning and force");
        // One sector track, no index mark, short third gap
        write_protect_i = 1'b0;
        put(32, 8'h4e);
        put(12, 8'h00);
        put(3, 8'hf5);
        put(1, 8'hfe);
        put(2, 8'h00);
        put(1, 8'h01);
        put(1, 8'h00);
        put(1, 8'hf7);
        put(22, 8'h4e);
        put(12, 8'h00);
        put(3, 8'hf5);
        put(1, 8'hfb);
        for (int i = 0; i < 128; i++)
            trk.push_back(8'(i));
        put(1, 8'hf7);
        put(2, 8'h4e);
        put(16, 8'h4e);
        load(CMD_WR_TRACK);
        foreach (trk[i])
            wr(trk[i]);
        for (int k = 0; k < 20 && drv.got.size() < 3 + trk.size(); k++)
            step(1);
        foreach (trk[i])
            `CHK(drv.got[3 + i], trk[i])
        pulse(mark_or_fault_i);
        rd(REG_STATUS, s);
        `CHK(s, 8'h23)
        pulse(cmd_done_i);
        endt("write track");
        write_protect_i = 1'b1;
        load(CMD_RD_TRACK);
        pulse(mark_or_fault_i);
        rd(REG_STATUS, s);
        `CHK(s, 8'h01)
        pulse(cmd_done_i);
        `CHK(interrupt_request_line_o, 1'b1)
        reset_i = 1'b1;
        step(1);
        reset_i = 1'b0;
        `CHK({dal_o, data_request_line_o, interrupt_request_line_o}, 10'h000)
        rd(REG_STATUS, s);
        `CHK(s & 8'hbf, 8'h20)
        endt("read track and reset");
        results();
    end
endmodule

/* File: dv/fdcst_drive_model.sv */
// Purpose: Drive side byte source and sink for the status block bench
// Assumes: Valid and ready are sampled on the rising edge of clk_sys_i
// Notes:   Sink takes a byte only every other cycle, so the buffer sees stalls
module fdcst_drive_model (
    input  wire logic       clk_sys_i,
    output logic            rd_byte_valid_o,
    output logic      [7:0] rd_byte_o,
    input  wire logic       rd_byte_ready_i,
    input  wire logic       wr_byte_valid_i,
    input  wire logic [7:0] wr_byte_i,
    output logic            wr_byte_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [$];
    initial
    begin
        rd_byte_valid_o = 1'b0;
        rd_byte_o       = 8'h00;
        wr_byte_ready_o = 1'b0;
    end
    // Slow sink: half rate keeps a write word waiting
    always @(posedge clk_sys_i)
    begin
        if (wr_byte_valid_i && wr_byte_ready_o)
            got.push_back(wr_byte_i);
        wr_byte_ready_o <= #1 ~wr_byte_ready_o;
    end
    task automatic send(input logic [7:0] b);
        rd_byte_valid_o = 1'b1;
        rd_byte_o       = b;
        @(posedge clk_sys_i);
        while (!rd_byte_ready_i)
            @(posedge clk_sys_i);
        #1;
        rd_byte_valid_o = 1'b0;
        // Released lines show no stale byte
        rd_byte_o       = ~b;
        @(posedge clk_sys_i);
        #1;
    endtask
endmodule

/* File: hdl/fdcst_status.sv */
// Purpose: Status word, data request and interrupt request of a floppy controller
// Assumes: All inputs synchronous to clk_sys_i; sequencer pulses its events
// Notes:   Two-entry byte buffer between sequencer and data holding register

module fdcst_status
    import fdcst_pkg::*;
#(
    parameter int DATA_W = 8
)(
    input  wire logic                   clk_sys_i,
    input  wire logic                   reset_i,
    input  wire logic                   master_reset_input_n_i,
    input  wire logic                   chip_select_n_i,
    input  wire logic                   read_enable_n_i,
    input  wire logic                   write_enable_n_i,
    input  wire logic [1:0]             reg_sel_i,
    input  wire logic [DATA_W-1:0]      dal_i,
    output logic      [DATA_W-1:0]      dal_o,
    output logic                        dal_oe_o,
    input  wire logic                   ready_i,
    input  wire logic                   head_load_output_i,
    input  wire logic                   head_load_timing_input_i,
    input  wire logic                   track_zero_input_n_i,
    input  wire logic                   index_pulse_input_n_i,
    input  wire logic                   write_protect_i,
    input  wire logic                   cmd_load_i,
    input  wire fdcst_pkg::fdcst_cmd_t  cmd_type_i,
    input  wire logic                   force_int_i,
    input  wire logic                   force_imm_i,
    input  wire logic                   cmd_done_i,
    input  wire logic                   seek_err_i,
    input  wire logic                   record_not_found_i,
    input  wire logic                   crc_err_i,
    input  wire logic                   mark_or_fault_i,
    input  wire logic                   byte_tick_i,
    input  wire logic                   rd_byte_valid_i,
    input  wire logic [DATA_W-1:0]      rd_byte_i,
    output logic                        rd_byte_ready_o,
    output logic                        wr_byte_valid_o,
    output logic      [DATA_W-1:0]      wr_byte_o,
    input  wire logic                   wr_byte_ready_i,
    output logic                        data_request_line_o,
    output logic                        interrupt_request_line_o,
    output logic                        cmd_refused_o
);
    import fdcst_pkg::*;

    typedef struct packed {
        fdcst_cmd_t                   cmd_type;
        logic                         busy;
        logic                         irq;
        logic                         imm_int;
        logic                         refused;
        logic                         err4;
        logic                         err3;
        logic                         lost;
        logic                         wp;
        logic                         s5evt;
        logic                         re_q;
        logic                         we_q;
        logic [DATA_W-1:0]            dal;
        logic [1:0][DATA_W-1:0]       mem;
        logic                         wptr;
        logic                         rptr;
        logic [1:0]                   cnt;
    } fdcst_state_t;

    fdcst_state_t               st_r;
    fdcst_state_t               st_nxt;
    logic                       selected;
    logic                       rd_act;
    logic                       wr_act;
    logic                       stat_rd;
    logic                       data_rd;
    logic                       data_wr;
    logic                       is_write;
    logic                       is_pos;
    logic                       not_ready;
    logic                       data_req;
    logic                       push;
    logic                       pop;
    logic [STATUS_W-1:0]        status_w;

    assign selected  = !chip_select_n_i;
    assign rd_act    = selected && !read_enable_n_i;
    assign wr_act    = selected && !write_enable_n_i;
    // Act once per strobe, on its leading edge
    assign stat_rd   = rd_act && !st_r.re_q && (reg_sel_i == REG_STATUS);
    assign data_rd   = rd_act && !st_r.re_q && (reg_sel_i == REG_DATA);
    assign data_wr   = wr_act && !st_r.we_q && (reg_sel_i == REG_DATA);
    assign is_write  = (st_r.cmd_type == CMD_WR_SECTOR) || (st_r.cmd_type == CMD_WR_TRACK);
    assign is_pos    = (st_r.cmd_type == CMD_POSITION);
    assign not_ready = !ready_i || !master_reset_input_n_i;
    // Empty register asks on writes, non-empty one on reads
    assign data_req  = is_write ? (st_r.busy && st_r.cnt == CNT_EMPTY)
                                : (st_r.cnt != CNT_EMPTY);
    // Byte stream is gap agnostic: short gaps and missing index mark are fine
    assign push      = is_write ? (data_wr && st_r.cnt != CNT_FULL)
                                : (rd_byte_valid_i && st_r.cnt != CNT_FULL);
    assign pop       = is_write ? (wr_byte_ready_i && st_r.cnt != CNT_EMPTY)
                                : (data_rd && st_r.cnt != CNT_EMPTY);

    always_comb
    begin
        status_w = '0;
        status_w[BIT_NOT_READY] = not_ready;
        status_w[BIT_BUSY]      = st_r.busy;
        if (is_pos)
        begin
            status_w[BIT_S6] = write_protect_i;
            status_w[BIT_S5] = head_load_output_i && head_load_timing_input_i;
            status_w[BIT_S4] = st_r.err4;
            status_w[BIT_S3] = st_r.err3;
            status_w[BIT_S2] = !track_zero_input_n_i;
            status_w[BIT_S1] = !index_pulse_input_n_i;
        end
        else
        begin
            status_w[BIT_S6] = is_write && st_r.wp;
            status_w[BIT_S5] = st_r.s5evt;
            status_w[BIT_S4] = st_r.err4;
            status_w[BIT_S3] = st_r.err3;
            status_w[BIT_S2] = st_r.lost;
            status_w[BIT_S1] = data_req;
        end
    end

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.re_q = rd_act;
        st_nxt.we_q = wr_act;
        st_nxt.refused = 1'b0;
        // Clears come first so that same-cycle events win
        if (stat_rd)
        begin
            st_nxt.dal = status_w;
            if (!st_r.imm_int)
            begin
                st_nxt.irq = 1'b0;
            end
        end
        if (data_rd)
        begin
            st_nxt.dal = st_r.mem[st_r.rptr];
        end
        if (cmd_load_i)
        begin
            st_nxt.cmd_type = cmd_type_i;
            st_nxt.err4     = 1'b0;
            st_nxt.err3     = 1'b0;
            st_nxt.lost     = 1'b0;
            st_nxt.wp       = 1'b0;
            st_nxt.s5evt    = 1'b0;
            st_nxt.irq      = 1'b0;
            st_nxt.imm_int  = 1'b0;
            st_nxt.cnt      = CNT_EMPTY;
            st_nxt.rptr     = 1'b0;
            st_nxt.wptr     = 1'b0;
            if (cmd_type_i != CMD_POSITION && not_ready)
            begin
                st_nxt.busy    = 1'b0;
                st_nxt.irq     = 1'b1;
                st_nxt.refused = 1'b1;
            end
            else
            begin
                st_nxt.busy = 1'b1;
            end
        end
        else if (force_int_i)
        begin
            // An immediate-free force or a command load lets the held request go again
            st_nxt.imm_int = force_imm_i;
            st_nxt.irq     = force_imm_i || (st_r.irq && !st_r.imm_int && !stat_rd);
            st_nxt.busy    = 1'b0;
            if (!st_r.busy)
            begin
                st_nxt.cmd_type = CMD_POSITION;
                st_nxt.err4     = 1'b0;
                st_nxt.err3     = 1'b0;
            end
        end
        else
        begin
            if (push)
            begin
                st_nxt.mem[st_r.wptr] = is_write ? dal_i : rd_byte_i;
                st_nxt.wptr           = !st_r.wptr;
            end
            if (pop)
            begin
                st_nxt.rptr = !st_r.rptr;
            end
            st_nxt.cnt = st_r.cnt + (push ? CNT_ONE : CNT_EMPTY) - (pop ? CNT_ONE : CNT_EMPTY);
        end
        if (st_r.busy && !force_int_i)
        begin
            if (is_pos ? seek_err_i : record_not_found_i)
            begin
                st_nxt.err4 = 1'b1;
            end
            if (crc_err_i)
            begin
                st_nxt.err3 = 1'b1;
            end
            if (mark_or_fault_i && (is_write || st_r.cmd_type == CMD_RD_SECTOR))
            begin
                st_nxt.s5evt = 1'b1;
            end
            if (is_write && write_protect_i)
            begin
                st_nxt.wp = 1'b1;
            end
            if (byte_tick_i && data_req && !is_pos)
            begin
                st_nxt.lost = 1'b1;
            end
            if (cmd_done_i)
            begin
                st_nxt.busy  = 1'b0;
                st_nxt.irq = 1'b1;
            end
        end
        if (!master_reset_input_n_i)
        begin
            st_nxt.busy     = 1'b0;
            st_nxt.cmd_type = CMD_POSITION;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_r          <= '0;
            st_r.cmd_type <= CMD_POSITION;
            st_r.dal      <= DAL_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign dal_o                    = st_r.dal;
    // Drives the bus one cycle behind the read edge; hold read enable longer
    assign dal_oe_o                 = rd_act && st_r.re_q;
    assign rd_byte_ready_o          = !is_write && st_r.cnt != CNT_FULL;
    assign wr_byte_valid_o          = is_write && st_r.cnt != CNT_EMPTY;
    assign wr_byte_o                = st_r.mem[st_r.rptr];
    assign data_request_line_o      = data_req;
    assign interrupt_request_line_o = st_r.irq;
    assign cmd_refused_o            = st_r.refused;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    a_cmd_refused_unready: assert property (
        cmd_load_i && cmd_type_i != CMD_POSITION && !ready_i
        |=> !st_r.busy && interrupt_request_line_o && cmd_refused_o)
        else $error("unready command was not refused");
    a_head_loaded_and: assert property (
        is_pos |-> status_w[BIT_S5] == (head_load_output_i && head_load_timing_input_i))
        else $error("head loaded bit wrong");
    a_seek_err_clear: assert property (
        cmd_load_i && !seek_err_i && !record_not_found_i |=> !st_r.err4)
        else $error("seek error not cleared on update");
    a_crc_flag_set: assert property (
        st_r.busy && crc_err_i && !force_int_i |=> status_w[BIT_S3])
        else $error("checksum error not flagged");
    a_track_zero_inv: assert property (
        is_pos |-> status_w[BIT_S2] != track_zero_input_n_i)
        else $error("track zero bit wrong");
    a_index_inv: assert property (
        is_pos |-> status_w[BIT_S1] != index_pulse_input_n_i)
        else $error("index bit wrong");
    a_busy_ends_done: assert property (
        st_r.busy && cmd_done_i && !cmd_load_i && !force_int_i
        |=> !status_w[BIT_BUSY] && st_r.irq)
        else $error("busy not cleared at done");
    a_wp_read_zero: assert property (
        !is_write && !is_pos |-> !status_w[BIT_S6])
        else $error("write protect shown on read");
    a_lost_data_set: assert property (
        st_r.busy && byte_tick_i && data_req && !is_pos && !cmd_load_i && !force_int_i
        && master_reset_input_n_i |=> status_w[BIT_S2] ##1 (st_r.lost || $past(cmd_load_i)))
        else $error("lost data not reported");
    a_drq_mirror_bit: assert property (
        !is_pos |-> status_w[BIT_S1] == data_request_line_o)
        else $error("status bit 1 differs from request line");
    a_drq_clear_read: assert property (
        data_rd && !is_write && st_r.cnt == CNT_ONE && !rd_byte_valid_i && !cmd_load_i
        && !force_int_i |=> !data_request_line_o)
        else $error("data read did not clear request");
    a_interrupt_request_line_clear_read: assert property (
        stat_rd && !st_r.imm_int && !cmd_done_i && !cmd_load_i && !force_int_i
        |=> !interrupt_request_line_o)
        else $error("status read did not clear interrupt");
    a_force_type_pos: assert property (
        force_int_i && !st_r.busy && !cmd_load_i |=> is_pos && !st_r.busy)
        else $error("idle force did not select positioning status");

    c_refused: cover property (cmd_load_i && not_ready && cmd_type_i != CMD_POSITION);
    c_buffer_full: cover property (st_r.cnt == CNT_FULL ##1 pop);
    c_lost_data: cover property (st_r.busy && byte_tick_i && data_req && !is_pos);
    c_imm_hold: cover property (st_r.imm_int && stat_rd);

endmodule
